// [include/cci_entry_if.sv]
// entry match port between the controller and the tag store
`timescale 1ns/1ns
interface cci_entry_if;
    import cci_pkg::*;
    logic [IDX_W-1:0] idx;
    logic kill;
    logic wr;
    cci_entry_t wdata;
    cci_entry_t rdata;
    modport ctrl (output idx, output kill, output wr, output wdata, input rdata);
    modport store (input idx, input kill, input wr, input wdata, output rdata);
endinterface

// [include/cci_pkg.sv]
// package for the configuration cache invalidation block
package cci_pkg;
    localparam int STREAM_W = 8;
    localparam int SUBSTREAM_W = 4;
    localparam int VM_IDENTIFIER_W = 8;
    localparam int ENTRIES = 8;
    localparam int IDX_W = 3;
    localparam int RANGE_W = 5;
    localparam logic [RANGE_W-1:0] RANGE_ALL = 5'h1F;
    localparam logic [SUBSTREAM_W-1:0] SUBSTREAM_ZERO = 4'h0;
    localparam logic [IDX_W-1:0] IDX_LAST = 3'h7;
    localparam logic [IDX_W-1:0] IDX_ZERO = 3'h0;

    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_ONE_DESC = 4'h1,
        OP_STREAM_DESC = 4'h2,
        OP_PART_MAP = 4'h3,
        OP_ALL_CONFIG = 4'h4,
        OP_STREAM_ENTRY = 4'h5,
        OP_STREAM_RANGE = 4'h6,
        OP_SYNC = 4'h7
    } cci_op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WALK = 2'b01,
        ST_DONE = 2'b11
    } cci_state_t;

    // decoded command queue entry
    typedef struct packed {
        cci_op_t op;
        logic sec;
        logic [STREAM_W-1:0] stream;
        logic [SUBSTREAM_W-1:0] substream;
        logic leaf;
        logic [RANGE_W-1:0] range;
        logic [VM_IDENTIFIER_W-1:0] vm_identifier;
    } cci_cmd_t;

    // one cached configuration entry
    typedef struct packed {
        logic valid;
        logic is_l1;
        logic is_pmap;
        logic sec;
        logic [STREAM_W-1:0] stream;
        logic [SUBSTREAM_W-1:0] substream;
        logic [VM_IDENTIFIER_W-1:0] vm_identifier;
    } cci_entry_t;
endpackage

// [test/cci_ctrl_assertions.sv]
// port assertions for the invalidation controller
`timescale 1ns/1ns
module cci_ctrl_assertions
    import cci_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic i_cmd_valid,
    input wire logic [3:0] i_cmd_opcode,
    input wire logic i_stage1_implemented,
    input wire logic i_partition_supported,
    input wire logic o_cmd_ready,
    input wire logic o_busy,
    input wire logic o_illegal_command_error,
    input wire logic o_sync_done
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);
    logic take;
    assign take = i_cmd_valid && o_cmd_ready;
    sequence walk_s;
        o_busy [*8];
    endsequence
    a_ready_busy: assert property (o_busy == !o_cmd_ready) else $error("busy and ready disagree");
    a_ill_stage1: assert property (take && !i_stage1_implemented && (i_cmd_opcode == OP_ONE_DESC ||
        i_cmd_opcode == OP_STREAM_DESC) |=> o_illegal_command_error) else $error("no stage1 error");
    a_ill_pmap: assert property (take && !i_partition_supported && i_cmd_opcode == OP_PART_MAP
        |=> o_illegal_command_error) else $error("no partition error");
    a_err_pulse: assert property (o_illegal_command_error |-> $past(take)) else $error("error without command");
    a_err_no_walk: assert property (o_illegal_command_error |-> o_cmd_ready) else $error("illegal walked");
    a_sync_answer: assert property (take && i_cmd_opcode == OP_SYNC |=> o_sync_done && o_cmd_ready)
        else $error("sync not answered");
    a_sync_idle: assert property (o_busy |-> !o_sync_done) else $error("sync during walk");
    a_flush_len: assert property (take && i_cmd_opcode == OP_ALL_CONFIG |=> walk_s ##1 o_busy ##1 o_cmd_ready)
        else $error("flush length");
    a_walk_bound: assert property (take && i_stage1_implemented && i_cmd_opcode == OP_STREAM_DESC
        |=> walk_s ##[2:10] o_cmd_ready) else $error("walk length");
endmodule
bind cci_ctrl cci_ctrl_assertions u_chk (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_cmd_valid(i_cmd_valid),
    .i_cmd_opcode(i_cmd_opcode), .i_stage1_implemented(i_stage1_implemented),
    .i_partition_supported(i_partition_supported), .o_cmd_ready(o_cmd_ready), .o_busy(o_busy),
    .o_illegal_command_error(o_illegal_command_error), .o_sync_done(o_sync_done));

// [test/cci_ctrl_tb.sv]
// self-checking bench for the invalidation controller
`timescale 1ns/1ns
module cci_ctrl_tb;
    import cci_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic fv = 1'b0;
    logic [IDX_W-1:0] fi = 3'h0;
    cci_entry_t fe = '0;
    logic s1 = 1'b1;
    logic pm = 1'b1;
    logic sel = 1'b0;
    logic [RANGE_W-1:0] rg = RANGE_ALL;
    localparam logic [7:0] HOST_OFS = 8'h10;
    logic v, lf, rdy, bsy, err, syn;
    logic [3:0] op;
    logic [7:0] st, vm;
    logic [3:0] sb;
    int error_cnt = 0;
    int samples_checked = 0;
    always #50 clk = ~clk;
    cci_sw_model sw (.i_sys_clk(clk), .i_ready(rdy), .o_valid(v), .o_op(op), .o_stream(st), .o_sub(sb),
        .o_leaf(lf), .o_vm_identifier(vm));
    cci_ctrl dut (.i_sys_clk(clk), .i_resetn(rstn), .i_cmd_valid(v), .i_cmd_opcode(op),
        .i_cmd_security_selector(sel), .i_cmd_stream_number(st), .i_cmd_substream_index(sb), .i_cmd_leaf(lf),
        .i_cmd_range(rg), .i_cmd_vm_identifier(vm), .i_fill_valid(fv), .i_fill_index(fi),
        .i_fill_entry(fe), .i_stage1_implemented(s1), .i_partition_supported(pm),
        .i_sec_partition_supported(1'b1), .i_sec_queue(1'b0), .o_cmd_ready(rdy), .o_busy(bsy),
        .o_illegal_command_error(err), .o_sync_done(syn));
    task automatic chk(input logic ok, input string m);
        samples_checked++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    task automatic fill(input logic [2:0] i, input logic l1, input logic p, input logic [7:0] s, input logic [3:0] b);
        @(negedge clk);
        fv = 1'b1;
        fi = i;
        fe = '{1'b1, l1, p, sel, s, b, s};
        @(negedge clk);
        fv = 1'b0;
        fe = ~fe;
    endtask
    // busy length is the only visible trace of how many slots a walk hit
    task automatic run(input logic [3:0] o, input logic [7:0] s, input logic [3:0] b, input logic l, input int n);
        int k;
        k = 0;
        sw.issue(o, s, b, l);
        while (bsy === 1'b1 && k < 60) begin
            k++;
            @(negedge clk);
        end
        chk(k == n, "walk length");
    endtask
    task automatic t_illegal;
        s1 = 1'b0;
        sw.issue(4'h1, 8'h05, 4'h0, 1'b1);
        chk(err === 1'b1 && rdy === 1'b1, "one desc legal");
        sw.issue(4'h2, 8'h05, 4'h0, 1'b1);
        chk(err === 1'b1, "stream desc legal");
        s1 = 1'b1;
        pm = 1'b0;
        sw.issue(4'h3, 8'h09, 4'h0, 1'b1);
        chk(err === 1'b1, "pmap legal");
        pm = 1'b1;
    endtask
    task automatic t_one_desc;
        fill(3'h0, 1'b0, 1'b0, 8'h05, 4'h0);
        fill(3'h1, 1'b0, 1'b0, 8'h05, 4'h2);
        fill(3'h2, 1'b1, 1'b0, 8'h05, 4'h0);
        run(4'h1, 8'h05, 4'h0, 1'b0, 11);
        run(4'h1, 8'h05, 4'h0, 1'b1, 9);
        run(4'h1, 8'h05, 4'h2, 1'b1, 10);
    endtask
    task automatic t_pmap;
        fill(3'h7, 1'b0, 1'b1, 8'h09, 4'h0);
        run(4'h3, 8'h09, 4'h0, 1'b1, 10);
    endtask
    task automatic t_stream_all;
        fill(3'h3, 1'b0, 1'b0, 8'h07, 4'h0);
        fill(3'h4, 1'b0, 1'b0, 8'h07, 4'h3);
        fill(3'h5, 1'b1, 1'b0, 8'h07, 4'h0);
        fill(3'h6, 1'b0, 1'b0, 8'h08, 4'h0);
        run(4'h2, 8'h07, 4'h0, 1'b1, 12);
        sw.issue(4'h7, 8'h00, 4'h0, 1'b1);
        chk(syn === 1'b1 && rdy === 1'b1, "sync");
        run(4'h4, 8'h07, 4'h0, 1'b1, 9);
        run(4'h1, 8'h08, 4'h0, 1'b1, 9);
    endtask
    // range 1 covers the aligned streams 0x20..0x23 and leaves partition maps alone
    task automatic t_range;
        rg = 5'h01;
        fill(3'h1, 1'b0, 1'b0, 8'h20, 4'h0);
        fill(3'h2, 1'b0, 1'b0, 8'h23, 4'h5);
        fill(3'h3, 1'b0, 1'b0, 8'h24, 4'h0);
        fill(3'h4, 1'b0, 1'b1, 8'h21, 4'h0);
        run(4'h6, 8'h22, 4'h0, 1'b1, 11);
        run(4'h5, 8'h24, 4'h0, 1'b1, 10);
        run(4'h3, 8'h21, 4'h0, 1'b1, 10);
        rg = RANGE_ALL;
    endtask
    // guest streams move by a fixed host offset; substreams pass through unchanged
    task automatic t_guest;
        fill(3'h0, 1'b0, 1'b0, 8'h05 + HOST_OFS, 4'h3);
        run(4'h1, 8'h05 + HOST_OFS, 4'h3, 1'b1, 10);
    endtask
    // secure entries outlive a flush of the other state; the secure selector is refused here for partition-map invalidation
    task automatic t_secure;
        sel = 1'b1;
        fill(3'h5, 1'b0, 1'b0, 8'h30, 4'h0);
        sel = 1'b0;
        run(4'h4, 8'h00, 4'h0, 1'b1, 9);
        sel = 1'b1;
        run(4'h1, 8'h30, 4'h0, 1'b1, 10);
        sw.issue(4'h3, 8'h30, 4'h0, 1'b1);
        chk(err === 1'b1 && rdy === 1'b1, "secure selector taken");
        sel = 1'b0;
    endtask
    task automatic report_and_stop;
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(negedge clk);
        rstn = 1'b1;
        t_illegal;
        t_one_desc;
        t_pmap;
        t_stream_all;
        t_range;
        t_guest;
        t_secure;
        report_and_stop;
    end
    initial begin
        #500000;
        error_cnt++;
        report_and_stop;
    end
endmodule

// [test/cci_sw_model.sv]
// software side that posts commands into the queue
`timescale 1ns/1ns
module cci_sw_model
    import cci_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_ready,
    output logic o_valid,
    output logic [3:0] o_op,
    output logic [STREAM_W-1:0] o_stream,
    output logic [SUBSTREAM_W-1:0] o_sub,
    output logic o_leaf,
    output logic [VM_IDENTIFIER_W-1:0] o_vm_identifier
);
    initial begin
        o_valid = 1'b0;
        o_op = 4'h0;
        o_stream = 8'h00;
        o_sub = 4'h0;
        o_leaf = 1'b1;
        o_vm_identifier = 8'h00;
    end
    // holds the entry until taken; released stream, substream and vm fields flip so stale values never look valid
    task automatic issue(input logic [3:0] op, input logic [7:0] s, input logic [3:0] sub, input logic lf);
        @(negedge i_sys_clk);
        o_valid = 1'b1;
        o_op = op;
        o_stream = s;
        o_sub = sub;
        o_leaf = lf;
        o_vm_identifier = s;
        while (!i_ready) @(negedge i_sys_clk);
        @(negedge i_sys_clk);
        o_valid = 1'b0;
        o_stream = ~s;
        o_sub = ~sub;
        o_vm_identifier = ~s;
    endtask
endmodule

// [verilog/cci_ctrl.sv]
// configuration cache invalidation controller
//
// Function
// - one-descriptor invalidate drops descriptor cached from table index x of stream
// - substream 0 drops table entry 0 regardless of default-substream role
// - out-of-range substream may do nothing or hit another index
// - leaf 0 also drops first-level descriptor pointer for target
// - leaf 1 may keep first-level pointers; here they are always dropped
// - descriptor invalidations raise illegal-command error without first stage
// - descriptor entries are tagged by stream and substream, not address
// - stream-descriptors invalidate drops all descriptors and pointers of stream
// - partition-map invalidate drops partition-map cache data for vm
// - partition-map invalidate illegal without support or bad selector
// - invalidate-all acts as stream range 31, stream ignored
// - invalidate-all also drops all vm-indexed data of security state
// - invalidate-all is a true flush, not a range walk
// - default-substream 0b10 entry 0 dropped by substream 0 command
// - sync consumed only once earlier invalidations have finished
// - range covers aligned block of two to range-plus-one streams
`timescale 1ns/1ns
module cci_ctrl
    import cci_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic i_cmd_valid,
    input wire logic [3:0] i_cmd_opcode,
    input wire logic i_cmd_security_selector,
    input wire logic [STREAM_W-1:0] i_cmd_stream_number,
    input wire logic [SUBSTREAM_W-1:0] i_cmd_substream_index,
    input wire logic i_cmd_leaf,
    input wire logic [RANGE_W-1:0] i_cmd_range,
    input wire logic [VM_IDENTIFIER_W-1:0] i_cmd_vm_identifier,
    input wire logic i_fill_valid,
    input wire logic [IDX_W-1:0] i_fill_index,
    input wire cci_entry_t i_fill_entry,
    input wire logic i_stage1_implemented,
    input wire logic i_partition_supported,
    input wire logic i_sec_partition_supported,
    input wire logic i_sec_queue,
    output logic o_cmd_ready,
    output logic o_busy,
    output logic o_illegal_command_error,
    output logic o_sync_done
);
    typedef struct packed {
        cci_state_t st;
        cci_cmd_t cmd;
        logic [IDX_W-1:0] idx;
        logic flush;
        logic ready;
        logic busy;
        logic err;
        logic sync;
    } cci_ctrl_t;

    cci_ctrl_t s_q;
    cci_ctrl_t s_d;
    cci_entry_if ent ();

    cci_tag_store u_store (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .port(ent.store)
    );

    cci_cmd_t dec;
    logic [STREAM_W-1:0] rmask;
    logic hit;
    logic legal;
    cci_entry_t e;

    always_comb begin
        dec.op = cci_op_t'(i_cmd_opcode);
        dec.sec = i_cmd_security_selector;
        dec.stream = i_cmd_stream_number;
        dec.substream = i_cmd_substream_index;
        dec.leaf = i_cmd_leaf;
        dec.range = i_cmd_range;
        dec.vm_identifier = i_cmd_vm_identifier;
    end

    // a nonsecure queue may not name the secure state; checked here for partition-map commands only
    always_comb begin
        legal = 1'b1;
        case (dec.op)
            OP_ONE_DESC, OP_STREAM_DESC: legal = i_stage1_implemented;
            OP_PART_MAP: legal = i_partition_supported && (!dec.sec || i_sec_partition_supported) &&
                (i_sec_queue || !dec.sec);
            default: legal = 1'b1;
        endcase
    end

    // aligned range mask: low range+1 bits ignored
    always_comb begin
        rmask = '1;
        for (int b = 0; b < STREAM_W; b++) begin
            if (b <= int'(s_q.cmd.range)) begin
                rmask[b] = 1'b0;
            end
        end
    end

    // match of the entry currently read during the walk
    // only entries of the commanded security state can match
    always_comb begin
        e = ent.rdata;
        hit = 1'b0;
        if (e.valid && e.sec == s_q.cmd.sec) begin
            case (s_q.cmd.op)
                // table index compare only; an out-of-range index simply misses
                // pointers for the stream dropped with either leaf value
                OP_ONE_DESC: hit = !e.is_pmap && e.stream == s_q.cmd.stream &&
                    (e.is_l1 || e.substream == s_q.cmd.substream);
                OP_STREAM_DESC: hit = !e.is_pmap && e.stream == s_q.cmd.stream;
                OP_PART_MAP: hit = e.is_pmap && e.vm_identifier == s_q.cmd.vm_identifier;
                OP_STREAM_ENTRY: hit = !e.is_pmap && e.stream == s_q.cmd.stream;
                OP_STREAM_RANGE: hit = !e.is_pmap && ((e.stream & rmask) == (s_q.cmd.stream & rmask));
                default: hit = 1'b0;
            endcase
        end
    end

    always_comb begin
        s_d = s_q;
        s_d.err = 1'b0;
        s_d.sync = 1'b0;
        ent.idx = s_q.idx;
        ent.kill = 1'b0;
        ent.wr = 1'b0;
        ent.wdata = i_fill_entry;
        case (s_q.st)
            ST_IDLE: begin
                if (i_fill_valid) begin
                    ent.idx = i_fill_index;
                    ent.wr = 1'b1;
                end
                // a fill landing in the same cycle as an accepted invalidation is dropped
                if (i_cmd_valid && s_q.ready) begin
                    if (!legal) begin
                        s_d.err = 1'b1;
                    end else if (dec.op == OP_SYNC) begin
                        s_d.sync = 1'b1;
                    end else if (dec.op != OP_NONE) begin
                        s_d.cmd = dec;
                        // everything of the state goes, so flush without compares
                        s_d.flush = (dec.op == OP_ALL_CONFIG) ||
                            (dec.op == OP_STREAM_RANGE && dec.range == RANGE_ALL);
                        s_d.idx = IDX_ZERO;
                        s_d.ready = 1'b0;
                        s_d.busy = 1'b1;
                        s_d.st = ST_WALK;
                        ent.idx = IDX_ZERO;
                        ent.wr = 1'b0;
                    end
                end
            end
            ST_WALK: begin
                // fills are ignored while walking; sync waits for ST_IDLE so it follows every kill
                // every kill names the commanded security state; the store spares other state
                ent.wdata = '0;
                ent.wdata.sec = s_q.cmd.sec;
                if (s_q.flush) begin
                    // read data lags the index, so the flush leaves the state check to the store
                    ent.idx = s_q.idx;
                    ent.kill = 1'b1;
                    s_d.idx = s_q.idx + 3'h1;
                    if (s_q.idx == IDX_LAST) begin
                        s_d.st = ST_DONE;
                    end
                end else begin
                    // read data lags index by one cycle; on a miss the read for idx+1 is issued now
                    ent.kill = hit;
                    ent.idx = hit ? s_q.idx : s_q.idx + 3'h1;
                    if (!hit) begin
                        s_d.idx = s_q.idx + 3'h1;
                        if (s_q.idx == IDX_LAST) begin
                            s_d.st = ST_DONE;
                        end
                    end
                end
            end
            ST_DONE: begin
                s_d.ready = 1'b1;
                s_d.busy = 1'b0;
                s_d.flush = 1'b0;
                s_d.st = ST_IDLE;
            end
            default: s_d.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            s_q <= '{
                st: ST_IDLE,
                cmd: '0,
                idx: IDX_ZERO,
                flush: 1'b0,
                ready: 1'b1,
                busy: 1'b0,
                err: 1'b0,
                sync: 1'b0
            };
        end else begin
            s_q <= s_d;
        end
    end

    // busy has its own flop so no output passes through logic
    assign o_cmd_ready = s_q.ready;
    assign o_busy = s_q.busy;
    assign o_illegal_command_error = s_q.err;
    assign o_sync_done = s_q.sync;
endmodule

// [verilog/cci_tag_store.sv]
// tag store of cached configuration entries, registered read data
`timescale 1ns/1ns
module cci_tag_store
    import cci_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    cci_entry_if.store port
);
    typedef struct packed {
        cci_entry_t [ENTRIES-1:0] mem;
        cci_entry_t rd;
    } cci_store_t;

    cci_store_t s_q;
    cci_store_t s_d;

    always_comb begin
        s_d = s_q;
        // a kill clears only the valid bit of the entry in one edge; the other fields are kept
        if (port.kill) begin
            // wdata.sec carries the state being invalidated; entries of the other state survive
            if (s_q.mem[port.idx].sec == port.wdata.sec) begin
                s_d.mem[port.idx].valid = 1'b0;
            end
        end else if (port.wr) begin
            s_d.mem[port.idx] = port.wdata;
        end
        s_d.rd = s_d.mem[port.idx];
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign port.rdata = s_q.rd;
endmodule
